// ---- bench/peripheral_interrupt_priority_ctrl_bench.sv ----
`timescale 1ns/1ns
`include "pipc_defs.svh"
module peripheral_interrupt_priority_ctrl_bench;
  localparam logic [11:0] A_EN1 = 12'h018, A_EN2 = 12'h01c, A_EN3 = 12'h020;
  localparam logic [11:0] A_PR1 = 12'h024, A_PR2 = 12'h028, A_PR3 = 12'h02c;
  logic mclk, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic single_chip_mode = 1'b0, sleep_req = 1'b0, pready, pslverr, irq_ack;
  logic irq_high, irq_low, wake;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_data;
  logic [3:0] ext_pin = 4'h0;
  logic [7:4] port_b_in = 4'h0;
  logic [7:0] periph_event_1 = 8'h0, periph_event_2 = 8'h0, periph_event_3 = 8'h0;
  logic [7:0] working_register, status_in, bank_select_register;
  logic [7:0] shadow_working, shadow_status, shadow_bank;
  logic [20:0] return_pc, stack_pc;
  int num_errors = 0;
  int total_checks = 0;

  pipc_ctrl #(.N_PINS(4)) uut (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_pin, .port_b_in, .periph_event_1, .periph_event_2,
    .periph_event_3, .single_chip_mode, .sleep_req, .irq_ack, .working_register, .status_in,
    .bank_select_register, .return_pc, .irq_high, .irq_low, .wake, .stack_pc,
    .shadow_working, .shadow_status, .shadow_bank);
  pipc_far_model far (.mclk, .reset, .irq_high, .irq_low, .irq_ack, .working_register,
    .status_in, .bank_select_register, .return_pc);

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one bus transfer; no fixed latency assumed, the watchdog cuts a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd_data, err);
  endtask : wr
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, rd_data, err);
    chk(n, x, rd_data);
  endtask : rd
  // request lines need two edges to follow a register change; allow three
  task automatic irq_is(input logic h, input logic l);
    repeat (3) @(posedge mclk);
    #1;
    chk("irq_high", {31'h0, h}, {31'h0, irq_high});
    chk("irq_low", {31'h0, l}, {31'h0, irq_low});
  endtask : irq_is
  task automatic pins(input logic [3:0] v);
    @(posedge mclk);
    ext_pin <= v;
    repeat (4) @(posedge mclk);
  endtask : pins

  task automatic t_regs();
    logic [11:0] a[6] = '{A_EN1, A_EN2, A_EN3, A_PR2, A_PR3, `PIPC_ADDR_RSTC};
    logic [31:0] x[6] = '{32'hff, 32'h5f, 32'h3f, 32'h5f, 32'h3f, 32'h9f};
    logic [7:0] r[6] = '{8'h00, 8'h00, 8'h00, 8'h5f, 8'h3f, 8'h1c};
    rd("prio1 reset", A_PR1, 32'hff);
    rd("ctrl2 reset", `PIPC_ADDR_CTRL2, 32'hf7);
    for (int i = 0; i < 6; i++) begin
      rd("reset value", a[i], {24'h0, r[i]});
      wr(a[i], 32'hff);
      rd("all ones", a[i], x[i]);
    end
    wr(`PIPC_ADDR_RSTC, 32'h0);
    rd("status bits kept", `PIPC_ADDR_RSTC, 32'h0c);
    wr(A_EN1, 32'h0);
    xfer(1'b1, 12'h03c, 32'hff, rd_data, err);
    chk("write error", 32'h1, {31'h0, err});
    rd("unmapped data", 12'h03c, 32'h0);
    chk("read error", 32'h1, {31'h0, err});
  endtask : t_regs
  // single level: group enable needed, priority bits ignored
  task automatic t_single();
    wr(A_EN1, 32'h02);
    wr(`PIPC_ADDR_CTRL1, 32'h80);
    @(posedge mclk);
    periph_event_1 <= 8'h82;
    @(posedge mclk);
    periph_event_1 <= 8'h00;
    irq_is(1'b0, 1'b0);
    rd("flag1", `PIPC_ADDR_FLAG1, 32'h02);
    wr(`PIPC_ADDR_CTRL1, 32'hc0);
    irq_is(1'b1, 1'b0);
    chk("shadow_working", 32'ha5, {24'h0, shadow_working});
    chk("stack_pc", 32'h1abcd, {11'h0, stack_pc});
    chk("shadow_status", 32'h3c, {24'h0, shadow_status});
    chk("shadow_bank", 32'h07, {24'h0, shadow_bank});
    wr(A_PR1, 32'hfd);
    irq_is(1'b1, 1'b0);
    wr(`PIPC_ADDR_RSTC, 32'h80);
    irq_is(1'b0, 1'b1);
    wr(A_PR1, 32'hff);
    irq_is(1'b1, 1'b0);
    wr(`PIPC_ADDR_FLAG1, 32'h0);
    irq_is(1'b0, 1'b0);
    // parallel port source passes once single-chip mode is on
    @(posedge mclk);
    single_chip_mode <= 1'b1;
    periph_event_1 <= 8'h80;
    @(posedge mclk);
    periph_event_1 <= 8'h00;
    rd("psp flag", `PIPC_ADDR_FLAG1, 32'h80);
    wr(A_EN1, 32'h0);
  endtask : t_single
  task automatic t_pins();
    wr(`PIPC_ADDR_CTRL1, 32'h0);
    pins(4'b1001);
    rd("pin0 rising", `PIPC_ADDR_CTRL1, 32'h02);
    rd("pin3 rising", `PIPC_ADDR_CTRL3, 32'hc0);
    pins(4'b0000);
    rd("pin3 falling", `PIPC_ADDR_CTRL3, 32'hc4);
    wr(`PIPC_ADDR_CTRL3, 32'he4);
    wr(`PIPC_ADDR_CTRL1, 32'hc0);
    irq_is(1'b1, 1'b0);
    wr(`PIPC_ADDR_CTRL2, 32'hf5);
    irq_is(1'b0, 1'b1);
    wr(`PIPC_ADDR_CTRL3, 32'he0);
    irq_is(1'b0, 1'b0);
    wr(`PIPC_ADDR_CTRL3, 32'hc8);
    wr(`PIPC_ADDR_CTRL1, 32'h0);
  endtask : t_pins
  // pin 1 enabled, global off: wakes but no vector
  task automatic t_sleep();
    logic seen = 1'b0;
    @(posedge mclk);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    rd("sleeping", `PIPC_ADDR_CORE, 32'h200 | 32'h100);
    @(posedge mclk);
    ext_pin <= 4'b0010;
    repeat (6) begin
      @(posedge mclk);
      #1;
      seen = seen | wake;
    end
    chk("wake", 32'h1, {31'h0, seen});
    irq_is(1'b0, 1'b0);
    wr(`PIPC_ADDR_CTRL3, 32'hc0);
  endtask : t_sleep
  task automatic t_timer();
    wr(`PIPC_ADDR_CTRL1, 32'h20);
    wr(`PIPC_ADDR_TMR0, 32'h2_00fd);
    rd("8-bit wrap", `PIPC_ADDR_CTRL1, 32'h24);
    wr(`PIPC_ADDR_CTRL1, 32'h0);
    wr(`PIPC_ADDR_TMR0, 32'h3_00fd);
    rd("16-bit low wrap", `PIPC_ADDR_CTRL1, 32'h0);
    wr(`PIPC_ADDR_TMR0, 32'h3_fffd);
    rd("16-bit wrap", `PIPC_ADDR_CTRL1, 32'h04);
    wr(`PIPC_ADDR_CTRL1, 32'ha4);
    irq_is(1'b1, 1'b0);
    wr(`PIPC_ADDR_TMR0, 32'h0);
    // clear first, so the write cannot wipe the change flag it is meant to show
    wr(`PIPC_ADDR_CTRL1, 32'h0);
    @(posedge mclk);
    port_b_in <= 4'h4;
    rd("port change", `PIPC_ADDR_CTRL1, 32'h01);
  endtask : t_timer

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_single();
    t_pins();
    t_sleep();
    t_timer();
    print_verdict();
  end
  // watchdog: the sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
endmodule : peripheral_interrupt_priority_ctrl_bench

// ---- bench/pipc_ctrl_monitor.sv ----
`timescale 1ns/1ns
// port-level checks of the interrupt controller
module pipc_ctrl_monitor #(
  parameter int N_PINS = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq_ack,
  input wire logic [7:0] working_register,
  input wire logic [20:0] return_pc,
  input wire logic irq_high,
  input wire logic irq_low,
  input wire logic wake,
  input wire logic [20:0] stack_pc,
  input wire logic [7:0] shadow_working,
  input wire logic [7:0] shadow_bank
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // bus timing: one wait state, one-cycle answer, idle data zero
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not one cycle after access");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero outside answer");
  property p_err_qual; pslverr |-> pready; endproperty
  a_err_qual: assert property (p_err_qual) else $error("pslverr without pready");
  property p_unmapped; psel && penable && !pready && paddr > 12'h038 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  // requests toward the core
  property p_one_vector; 1'b1 |-> !(irq_high && irq_low); endproperty
  a_one_vector: assert property (p_one_vector) else $error("both vectors requested");
  property p_wake_pulse; wake |=> !wake; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  property p_reset_quiet; $past(reset) |-> !irq_high && !irq_low && !wake; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("request right after reset");
  // context save: capture on ack only, held otherwise
  property p_ctx_capture;
    irq_ack |=> shadow_working == $past(working_register) && stack_pc == $past(return_pc);
  endproperty
  a_ctx_capture: assert property (p_ctx_capture) else $error("context not captured");
  property p_ctx_hold; !irq_ack |=> $stable(shadow_working) && $stable(shadow_bank); endproperty
  a_ctx_hold: assert property (p_ctx_hold) else $error("context changed without ack");
  c_low: cover property (irq_low);
  c_wake: cover property (wake);
  c_err: cover property (pslverr);
  c_ack: cover property (irq_ack);
endmodule : pipc_ctrl_monitor

bind pipc_ctrl pipc_ctrl_monitor #(.N_PINS(N_PINS)) u_mon (.mclk, .reset, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .irq_ack, .working_register, .return_pc, .irq_high,
  .irq_low, .wake, .stack_pc, .shadow_working, .shadow_bank);

// ---- bench/pipc_far_model.sv ----
`timescale 1ns/1ns
// core side: takes each new request once and offers its context
module pipc_far_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic irq_high,
  input wire logic irq_low,
  output logic irq_ack,
  output logic [7:0] working_register,
  output logic [7:0] status_in,
  output logic [7:0] bank_select_register,
  output logic [20:0] return_pc
);
  logic pend_reg;
  // a held request is not taken twice, as a real core is busy in its handler
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_ack <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      irq_ack <= (irq_high | irq_low) & ~pend_reg;
      pend_reg <= irq_high | irq_low;
    end
  end
  // context valid only with the ack; bytes inverted and return_pc changed otherwise so a stray capture shows
  assign working_register = irq_ack ? 8'ha5 : 8'h5a;
  assign status_in = irq_ack ? 8'h3c : 8'hc3;
  assign bank_select_register = irq_ack ? 8'h07 : 8'hf8;
  assign return_pc = irq_ack ? 21'h1abcd : 21'h0e432;
endmodule : pipc_far_model

// ---- rtl/pipc_ctrl.sv ----
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "pipc_defs.svh"
module pipc_ctrl #(
  parameter int N_PINS = 4
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] ext_pin,
  input wire logic [7:4] port_b_in,
  input wire logic [7:0] periph_event_1,
  input wire logic [7:0] periph_event_2,
  input wire logic [7:0] periph_event_3,
  input wire logic single_chip_mode,
  input wire logic sleep_req,
  input wire logic irq_ack,
  input wire logic [7:0] working_register,
  input wire logic [7:0] status_in,
  input wire logic [7:0] bank_select_register,
  input wire logic [20:0] return_pc,
  output logic irq_high,
  output logic irq_low,
  output logic wake,
  output logic [20:0] stack_pc,
  output logic [7:0] shadow_working,
  output logic [7:0] shadow_status,
  output logic [7:0] shadow_bank
);
  import pipc_pkg::*;
  if (N_PINS != 4) begin : g_pin_check
    $error("pipc_ctrl serves exactly four external pins");
  end

  // register state
  pipc_byte_t main_irq_control_1_reg, main_irq_control_1_next;
  pipc_byte_t main_irq_control_2_reg, main_irq_control_2_next;
  pipc_byte_t main_irq_control_3_reg, main_irq_control_3_next;
  pipc_byte_t flag1_reg, flag1_next, flag2_reg, flag2_next, flag3_reg, flag3_next;
  pipc_byte_t peripheral_irq_enable_1_reg, peripheral_irq_enable_1_next, peripheral_irq_enable_2_reg, peripheral_irq_enable_2_next, peripheral_irq_enable_3_reg, peripheral_irq_enable_3_next;
  pipc_byte_t pip1_reg, pip1_next, pip2_reg, pip2_next, pip3_reg, pip3_next;
  pipc_byte_t rstc_reg, rstc_next;
  logic [15:0] tmr0_reg, tmr0_next;
  logic tmr0_16bit_reg, tmr0_16bit_next;
  logic tmr0_run_reg, tmr0_run_next;
  logic [7:4] portb_prev_reg, portb_prev_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic irq_high_reg, irq_high_next, irq_low_reg, irq_low_next;
  logic wake_reg, wake_next;
  pipc_state_t state_reg, state_next;
  logic [20:0] stack_pc_reg, stack_pc_next;
  pipc_byte_t sh_w_reg, sh_w_next, sh_s_reg, sh_s_next, sh_b_reg, sh_b_next;

  // external pin detectors; edge selects in control 2, pin 0 at bit 6 down to pin 3 at bit 3
  logic [3:0] pin_hit;
  logic [3:0] edge_sel;
  assign edge_sel = {main_irq_control_2_reg[3], main_irq_control_2_reg[4],
                     main_irq_control_2_reg[5], main_irq_control_2_reg[6]};
  for (genvar i = 0; i < 4; i++) begin : g_pin
    pipc_edge_if eif ();
    assign eif.pin = ext_pin[i];
    assign eif.rising_sel = edge_sel[i];
    assign pin_hit[i] = eif.hit;
    pipc_edge_det u_det (.mclk(mclk), .reset(reset), .e(eif));
  end

  // apb decode: access phase, one wait state
  logic wr, rd;
  logic [7:0] wb;
  assign wr = psel & penable & pwrite & ~pready_reg;
  assign rd = psel & penable & ~pwrite & ~pready_reg;
  assign wb = pwdata[7:0];

  // source events
  logic t0_wrap;
  logic rb_change;
  logic [7:0] ev1;
  always_comb begin
    t0_wrap = tmr0_run_reg & (tmr0_16bit_reg ? (tmr0_reg == 16'hffff)
                                             : (tmr0_reg[7:0] == 8'hff));
    rb_change = |(port_b_in ^ portb_prev_reg);
    ev1 = periph_event_1;
    ev1[`PIPC_BIT_PSP] = periph_event_1[`PIPC_BIT_PSP] & single_chip_mode;
  end

  // register writes; hardware sets win over software clears
  always_comb begin
    main_irq_control_1_next = main_irq_control_1_reg;
    main_irq_control_2_next = main_irq_control_2_reg;
    main_irq_control_3_next = main_irq_control_3_reg;
    flag1_next = flag1_reg;
    flag2_next = flag2_reg;
    flag3_next = flag3_reg;
    peripheral_irq_enable_1_next = peripheral_irq_enable_1_reg;
    peripheral_irq_enable_2_next = peripheral_irq_enable_2_reg;
    peripheral_irq_enable_3_next = peripheral_irq_enable_3_reg;
    pip1_next = pip1_reg;
    pip2_next = pip2_reg;
    pip3_next = pip3_reg;
    rstc_next = rstc_reg;
    tmr0_16bit_next = tmr0_16bit_reg;
    tmr0_run_next = tmr0_run_reg;
    if (wr) begin
      if (paddr == `PIPC_ADDR_CTRL1) begin
        main_irq_control_1_next = wb;
      end else if (paddr == `PIPC_ADDR_CTRL2) begin
        main_irq_control_2_next = wb;
      end else if (paddr == `PIPC_ADDR_CTRL3) begin
        main_irq_control_3_next = wb;
      end else if (paddr == `PIPC_ADDR_FLAG1) begin
        flag1_next = wb;
      end else if (paddr == `PIPC_ADDR_FLAG2) begin
        flag2_next = wb & `PIPC_MASK_E2;
      end else if (paddr == `PIPC_ADDR_FLAG3) begin
        flag3_next = wb & `PIPC_MASK_E3;
      end else if (paddr == `PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_1) begin
        peripheral_irq_enable_1_next = wb & `PIPC_MASK_E1;
      end else if (paddr == `PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_2) begin
        peripheral_irq_enable_2_next = wb & `PIPC_MASK_E2;
      end else if (paddr == `PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_3) begin
        peripheral_irq_enable_3_next = wb & `PIPC_MASK_E3;
      end else if (paddr == `PIPC_ADDR_PIP1) begin
        pip1_next = wb & `PIPC_MASK_E1;
      end else if (paddr == `PIPC_ADDR_PIP2) begin
        pip2_next = wb & `PIPC_MASK_E2;
      end else if (paddr == `PIPC_ADDR_PIP3) begin
        pip3_next = wb & `PIPC_MASK_E3;
      end else if (paddr == `PIPC_ADDR_RSTC) begin
        // only priority enable, reset-instruction, power-on and brown-out bits written
        rstc_next = (rstc_reg & ~`PIPC_RSTC_WMASK) | (wb & `PIPC_RSTC_WMASK);
      end else if (paddr == `PIPC_ADDR_TMR0) begin
        tmr0_16bit_next = pwdata[16];
        tmr0_run_next = pwdata[17];
      end
    end
    // event sets after the writes so a same-cycle clear loses
    if (t0_wrap) main_irq_control_1_next[`PIPC_BIT_T0F] = 1'b1;
    if (rb_change) main_irq_control_1_next[`PIPC_BIT_RBF] = 1'b1;
    if (pin_hit[0]) main_irq_control_1_next[`PIPC_BIT_I0F] = 1'b1;
    main_irq_control_3_next[2:0] = main_irq_control_3_next[2:0] | pin_hit[3:1];
    flag1_next = flag1_next | ev1;
    flag2_next = flag2_next | (periph_event_2 & `PIPC_MASK_E2);
    flag3_next = flag3_next | (periph_event_3 & `PIPC_MASK_E3);
  end

  // timer zero and port b sampling
  always_comb begin
    tmr0_next = tmr0_reg;
    if (wr && paddr == `PIPC_ADDR_TMR0) begin
      tmr0_next = pwdata[15:0];
    end else if (tmr0_run_reg) begin
      tmr0_next = tmr0_16bit_reg ? tmr0_reg + 16'h0001
                                 : {8'h00, tmr0_reg[7:0] + 8'h01};
    end
    portb_prev_next = port_b_in;
  end

  // request routing
  logic priority_levels_enable, global_irq_enable, peripheral_group_enable;
  logic [3:0] pin_en, pin_pri;
  logic [7:0] pa1, pa2, pa3;
  logic hi_any, lo_any, periph_hi, periph_lo, core_hi, core_lo, any_pend;
  always_comb begin
    priority_levels_enable = rstc_reg[`PIPC_BIT_PRIORITY_LEVELS_ENABLE];
    global_irq_enable = main_irq_control_1_reg[`PIPC_BIT_GIE];
    peripheral_group_enable = main_irq_control_1_reg[`PIPC_BIT_PERIPHERAL_GROUP_ENABLE];
    pin_en = {main_irq_control_3_reg[5:3], main_irq_control_1_reg[`PIPC_BIT_I0E]};
    pin_pri = {main_irq_control_2_reg[1], main_irq_control_3_reg[7:6], 1'b1};
    pa1 = flag1_reg & peripheral_irq_enable_1_reg;
    pa1[`PIPC_BIT_PSP] = pa1[`PIPC_BIT_PSP] & single_chip_mode;
    pa2 = flag2_reg & peripheral_irq_enable_2_reg;
    pa3 = flag3_reg & peripheral_irq_enable_3_reg;
    // priority bits only matter with levels enabled
    periph_hi = |(pa1 & pip1_reg) | |(pa2 & pip2_reg) | |(pa3 & pip3_reg);
    periph_lo = |(pa1 & ~pip1_reg) | |(pa2 & ~pip2_reg) | |(pa3 & ~pip3_reg);
    core_hi = |(pin_en & {main_irq_control_3_reg[2:0],
                          main_irq_control_1_reg[`PIPC_BIT_I0F]} & pin_pri)
      | (main_irq_control_1_reg[`PIPC_BIT_T0IE] & main_irq_control_1_reg[`PIPC_BIT_T0F]
         & main_irq_control_2_reg[2])
      | (main_irq_control_1_reg[`PIPC_BIT_RBE] & main_irq_control_1_reg[`PIPC_BIT_RBF]
         & main_irq_control_2_reg[0]);
    core_lo = |(pin_en & {main_irq_control_3_reg[2:0],
                          main_irq_control_1_reg[`PIPC_BIT_I0F]} & ~pin_pri)
      | (main_irq_control_1_reg[`PIPC_BIT_T0IE] & main_irq_control_1_reg[`PIPC_BIT_T0F]
         & ~main_irq_control_2_reg[2])
      | (main_irq_control_1_reg[`PIPC_BIT_RBE] & main_irq_control_1_reg[`PIPC_BIT_RBF]
         & ~main_irq_control_2_reg[0]);
    any_pend = core_hi | core_lo | ((periph_hi | periph_lo) & (priority_levels_enable | peripheral_group_enable));
    if (priority_levels_enable) begin
      // levels on: global bit enables high, global and peripheral-group bits together enable low
      hi_any = global_irq_enable & (core_hi | periph_hi);
      lo_any = global_irq_enable & peripheral_group_enable & (core_lo | periph_lo);
    end else begin
      // single vector: peripherals additionally need the group enable
      hi_any = global_irq_enable & (core_hi | core_lo | (peripheral_group_enable & (periph_hi | periph_lo)));
      lo_any = 1'b0;
    end
  end

  // sleep, wake and context capture on entry
  always_comb begin
    state_next = state_reg;
    wake_next = 1'b0;
    case (state_reg)
      PIPC_RUN: begin
        if (sleep_req) state_next = PIPC_SLEEP;
      end
      PIPC_SLEEP: begin
        // wake regardless of global enable; vectoring then follows irq outputs
        if (any_pend) begin
          wake_next = 1'b1;
          state_next = PIPC_RUN;
        end
      end
      default: state_next = PIPC_RUN;
    endcase
    irq_high_next = hi_any & (state_reg == PIPC_RUN);
    irq_low_next = lo_any & ~hi_any & (state_reg == PIPC_RUN);
    stack_pc_next = stack_pc_reg;
    sh_w_next = sh_w_reg;
    sh_s_next = sh_s_reg;
    sh_b_next = sh_b_reg;
    if (irq_ack) begin
      stack_pc_next = return_pc;
      sh_w_next = working_register;
      sh_s_next = status_in;
      sh_b_next = bank_select_register;
    end
  end

  // read mux
  always_comb begin
    prdata_next = 32'h0000_0000;
    pslverr_next = 1'b0;
    pready_next = psel & penable & ~pready_reg;
    if (psel & penable & ~pready_reg) begin
      if (paddr == `PIPC_ADDR_CTRL1) begin
        prdata_next[7:0] = main_irq_control_1_reg;
      end else if (paddr == `PIPC_ADDR_CTRL2) begin
        prdata_next[7:0] = main_irq_control_2_reg;
      end else if (paddr == `PIPC_ADDR_CTRL3) begin
        prdata_next[7:0] = main_irq_control_3_reg;
      end else if (paddr == `PIPC_ADDR_FLAG1) begin
        prdata_next[7:0] = flag1_reg;
      end else if (paddr == `PIPC_ADDR_FLAG2) begin
        prdata_next[7:0] = flag2_reg;
      end else if (paddr == `PIPC_ADDR_FLAG3) begin
        prdata_next[7:0] = flag3_reg;
      end else if (paddr == `PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_1) begin
        prdata_next[7:0] = peripheral_irq_enable_1_reg;
      end else if (paddr == `PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_2) begin
        prdata_next[7:0] = peripheral_irq_enable_2_reg;
      end else if (paddr == `PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_3) begin
        prdata_next[7:0] = peripheral_irq_enable_3_reg;
      end else if (paddr == `PIPC_ADDR_PIP1) begin
        prdata_next[7:0] = pip1_reg;
      end else if (paddr == `PIPC_ADDR_PIP2) begin
        prdata_next[7:0] = pip2_reg;
      end else if (paddr == `PIPC_ADDR_PIP3) begin
        prdata_next[7:0] = pip3_reg;
      end else if (paddr == `PIPC_ADDR_RSTC) begin
        prdata_next[7:0] = rstc_reg;
      end else if (paddr == `PIPC_ADDR_TMR0) begin
        prdata_next = {14'h0000, tmr0_run_reg, tmr0_16bit_reg, tmr0_reg};
      end else if (paddr == `PIPC_ADDR_CORE) begin
        prdata_next = {22'h00_0000, state_reg == PIPC_SLEEP, priority_levels_enable, hi_any, lo_any, 6'h00};
      end else begin
        pslverr_next = 1'b1; // unmapped address
      end
    end
  end

  // all registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      main_irq_control_1_reg <= 8'h00;
      main_irq_control_2_reg <= `PIPC_RST_CTRL2;
      main_irq_control_3_reg <= `PIPC_RST_CTRL3;
      flag1_reg <= 8'h00;
      flag2_reg <= 8'h00;
      flag3_reg <= 8'h00;
      peripheral_irq_enable_1_reg <= `PIPC_RST_ENA;
      peripheral_irq_enable_2_reg <= `PIPC_RST_ENA;
      peripheral_irq_enable_3_reg <= `PIPC_RST_ENA;
      pip1_reg <= `PIPC_RST_PRI1;
      pip2_reg <= `PIPC_RST_PRI2;
      pip3_reg <= `PIPC_RST_PRI3;
      rstc_reg <= `PIPC_RST_RSTC;
      tmr0_reg <= 16'h0000;
      tmr0_16bit_reg <= 1'b0;
      tmr0_run_reg <= 1'b0;
      portb_prev_reg <= 4'h0;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      irq_high_reg <= 1'b0;
      irq_low_reg <= 1'b0;
      wake_reg <= 1'b0;
      state_reg <= PIPC_RUN;
      stack_pc_reg <= 21'h00_0000;
      sh_w_reg <= 8'h00;
      sh_s_reg <= 8'h00;
      sh_b_reg <= 8'h00;
    end else begin
      main_irq_control_1_reg <= main_irq_control_1_next;
      main_irq_control_2_reg <= main_irq_control_2_next;
      main_irq_control_3_reg <= main_irq_control_3_next;
      flag1_reg <= flag1_next;
      flag2_reg <= flag2_next;
      flag3_reg <= flag3_next;
      peripheral_irq_enable_1_reg <= peripheral_irq_enable_1_next;
      peripheral_irq_enable_2_reg <= peripheral_irq_enable_2_next;
      peripheral_irq_enable_3_reg <= peripheral_irq_enable_3_next;
      pip1_reg <= pip1_next;
      pip2_reg <= pip2_next;
      pip3_reg <= pip3_next;
      rstc_reg <= rstc_next;
      tmr0_reg <= tmr0_next;
      tmr0_16bit_reg <= tmr0_16bit_next;
      tmr0_run_reg <= tmr0_run_next;
      portb_prev_reg <= portb_prev_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      irq_high_reg <= irq_high_next;
      irq_low_reg <= irq_low_next;
      wake_reg <= wake_next;
      state_reg <= state_next;
      stack_pc_reg <= stack_pc_next;
      sh_w_reg <= sh_w_next;
      sh_s_reg <= sh_s_next;
      sh_b_reg <= sh_b_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq_high = irq_high_reg;
  assign irq_low = irq_low_reg;
  assign wake = wake_reg;
  assign stack_pc = stack_pc_reg;
  assign shadow_working = sh_w_reg;
  assign shadow_status = sh_s_reg;
  assign shadow_bank = sh_b_reg;
endmodule : pipc_ctrl

// ---- rtl/pipc_defs.svh ----
`ifndef PIPC_DEFS_SVH
`define PIPC_DEFS_SVH
`define PIPC_ADDR_CTRL1 12'h000
`define PIPC_ADDR_CTRL2 12'h004
`define PIPC_ADDR_CTRL3 12'h008
`define PIPC_ADDR_FLAG1 12'h00c
`define PIPC_ADDR_FLAG2 12'h010
`define PIPC_ADDR_FLAG3 12'h014
`define PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_1 12'h018
`define PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_2 12'h01c
`define PIPC_ADDR_PERIPHERAL_IRQ_ENABLE_3 12'h020
`define PIPC_ADDR_PIP1 12'h024
`define PIPC_ADDR_PIP2 12'h028
`define PIPC_ADDR_PIP3 12'h02c
`define PIPC_ADDR_RSTC 12'h030
`define PIPC_ADDR_TMR0 12'h034
`define PIPC_ADDR_CORE 12'h038
`define PIPC_MASK_E1 8'hff
`define PIPC_MASK_E2 8'h5f
`define PIPC_MASK_E3 8'h3f
`define PIPC_RST_ENA 8'h00
`define PIPC_RST_PRI1 8'hff
`define PIPC_RST_PRI2 8'h5f
`define PIPC_RST_PRI3 8'h3f
`define PIPC_RST_RSTC 8'h1c
`define PIPC_RSTC_WMASK 8'h93
`define PIPC_RST_CTRL2 8'hf7
`define PIPC_RST_CTRL3 8'hc0
`define PIPC_BIT_GIE 7
`define PIPC_BIT_PERIPHERAL_GROUP_ENABLE 6
`define PIPC_BIT_T0IE 5
`define PIPC_BIT_I0E 4
`define PIPC_BIT_RBE 3
`define PIPC_BIT_T0F 2
`define PIPC_BIT_I0F 1
`define PIPC_BIT_RBF 0
`define PIPC_BIT_PRIORITY_LEVELS_ENABLE 7
`define PIPC_BIT_PSP 7
`endif

// ---- rtl/pipc_edge_det.sv ----
`timescale 1ns/1ns
// edge detector for one external interrupt pin
module pipc_edge_det (
  input wire logic mclk,
  input wire logic reset,
  pipc_edge_if.det e
);
  import pipc_pkg::*;
  logic prev_reg;
  logic prev_next;
  // previous level; pins are taken as already synchronous
  always_comb begin
    prev_next = e.pin;
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
    end
  end
  // selected edge only
  assign e.hit = e.rising_sel ? (e.pin & ~prev_reg) : (~e.pin & prev_reg);
endmodule : pipc_edge_det

// ---- rtl/pipc_if.sv ----
`timescale 1ns/1ns
// one external pin's detection result and control
interface pipc_edge_if;
  logic pin;
  logic rising_sel;
  logic hit;
  modport det (input pin, input rising_sel, output hit);
  modport ctl (output pin, output rising_sel, input hit);
endinterface : pipc_edge_if

// ---- rtl/pipc_pkg.sv ----
package pipc_pkg;
  typedef logic [7:0] pipc_byte_t;
  typedef enum logic [1:0] {PIPC_RUN, PIPC_SLEEP} pipc_state_t;
endpackage : pipc_pkg
